// ==== rtl/ddrio_pkg.sv ====
/*
  Package for the double-rate pin path: reset values and the packed
  carriers that group the input, output and enable streams.
  Assumes a single common clock; nothing here is clocked.
*/
package ddrio_pkg;

  // ==========================================================
  // reset values
  localparam logic RISE_CAP_RST = 1'h0;
  localparam logic FALL_CAP_RST = 1'h0;
  localparam logic HIGH_PH_RST  = 1'h0;
  localparam logic LOW_PH_RST   = 1'h0;
  localparam logic OE_RST       = 1'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic rise;   // value caught on the rising edge, retimed
    logic fall;   // value caught on the falling edge, retimed
  } ddrio_pair_t;

  typedef struct packed {
    logic pin_i;  // pin level as seen by the input buffer
  } ddrio_pin_in_t;

  typedef struct packed {
    logic pin_o;  // level driven when enabled
    logic pin_oe; // high while this end drives the pin
  } ddrio_pin_out_t;

endpackage : ddrio_pkg

// ==== rtl/ddrio_path.sv ====
/*
  Double-rate pin path: input capture on both edges realigned to the
  rising edge, two-phase output multiplexed by clock level, and a
  tri-state enable for the shared pin.
  Assumes the pin is resolved outside from pin_o, pin_oe and the far
  driver, and that the far party drives only while pin_oe is low.
*/
`timescale 1ns/100ps

module ddrio_path
  import ddrio_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           clk_en,
  input  wire ddrio_pin_in_t  pin_in,
  output ddrio_pin_out_t      pin_out,
  input  wire logic           data_in_h,
  input  wire logic           data_in_l,
  input  wire logic           drive_en,
  output ddrio_pair_t         rx_pair
);

  // ==========================================================
  // input capture
  // the pin is caught twice per period: once as the clock rises and
  // once as it falls; both copies are then moved onto the rising edge
  // so the core sees one pair per cycle, rise bit first in time.
  // the falling copy has only half a period to reach its retiming
  // flop, so this is the path to watch when placing the logic.
  logic rise_cap_r;
  logic fall_cap_r;
  logic rise_sync_r;
  logic fall_sync_r;

  // rising-edge capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_cap_r <= RISE_CAP_RST;
    end else if (clk_en) begin
      rise_cap_r <= pin_in.pin_i;
    end
  end

  // falling-edge capture; clk_en is assumed stable across the low half
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fall_cap_r <= FALL_CAP_RST;
    end else if (clk_en) begin
      fall_cap_r <= pin_in.pin_i;
    end
  end

  // realign both streams; fall half-cycle path is the tight one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_sync_r <= RISE_CAP_RST;
      fall_sync_r <= FALL_CAP_RST;
    end else if (clk_en) begin
      rise_sync_r <= rise_cap_r;
      fall_sync_r <= fall_cap_r;
    end
  end

  assign rx_pair = '{rise: rise_sync_r, fall: fall_sync_r};

  // ==========================================================
  // output phases
  // two values per period leave on the pin: the high-phase register
  // while the clock is high, the low-phase register while it is low.
  // both registers load on the rising edge, so a pair taken at edge N
  // shows high half first, low half second, until the next edge.
  // the enable is registered too, so it lines up with its data.
  logic high_ph_r;
  logic low_ph_r;
  logic oe_r;

  // both phase registers on the common rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_ph_r <= HIGH_PH_RST;
      low_ph_r  <= LOW_PH_RST;
    end else if (clk_en) begin
      high_ph_r <= data_in_h;
      low_ph_r  <= data_in_l;
    end
  end

  // enable registered to line up with the data it guards
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_r <= OE_RST;
    end else if (clk_en) begin
      oe_r <= drive_en;
    end
  end

  // clock-level mux; glitch risk is the price of a plain gate mux
  assign pin_out.pin_o  = clk ? high_ph_r : low_ph_r;
  assign pin_out.pin_oe = oe_r;

  // ==========================================================
  // checks
  // reset is released on a rising edge, and the flops loaded at that
  // edge still saw reset; so reset_n also stands in the antecedents,
  // which keeps an attempt started on that edge vacuous

  // high once a rising edge has passed with reset held; the edges
  // before that find flops that have not yet seen any reset
  logic rst_held_r;

  always_ff @(posedge clk) begin
    rst_held_r <= !reset_n;
  end

  // released pin and cleared streams while reset is held
  a_reset_quiet: assert property (@(posedge clk)
    !reset_n && rst_held_r
      |-> !pin_out.pin_oe && !pin_out.pin_o && rx_pair == '0)
    else $error("outputs not quiet in reset");

  // high half, seen just before the falling edge
  a_high_phase_out: assert property (@(negedge clk)
    disable iff (!reset_n)
    pin_out.pin_o == high_ph_r)
    else $error("high half shows wrong register");

  // low half, seen just before the rising edge
  a_low_phase_out: assert property (@(posedge clk)
    disable iff (!reset_n)
    pin_out.pin_o == low_ph_r)
    else $error("low half shows wrong register");

  // rising capture holds the pin level of its own edge
  a_rise_capture: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en |=> rise_cap_r == $past(pin_in.pin_i))
    else $error("rising capture mismatch");

  // falling capture holds the pin level of its own edge
  a_fall_capture: assert property (@(negedge clk)
    disable iff (!reset_n)
    reset_n && clk_en |=> fall_cap_r == $past(pin_in.pin_i))
    else $error("falling capture mismatch");

  // rise bit reaches the core two rising edges after the pin
  a_rise_realign: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && $past(reset_n) && clk_en && $past(clk_en)
      |=> rx_pair.rise == $past(pin_in.pin_i, 2))
    else $error("rising stream not realigned");

  // fall bit moves onto the rising edge one edge later
  a_fall_realign: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en |=> rx_pair.fall == $past(fall_cap_r))
    else $error("falling stream not realigned");

  // both phase registers load from the core on the rising edge
  a_phase_load: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en |=> high_ph_r == $past(data_in_h)
      && low_ph_r == $past(data_in_l))
    else $error("phase registers not loaded");

  // high half of the last period carried the high phase
  a_high_drive: assert property (@(negedge clk)
    disable iff (!reset_n)
    $past(pin_out.pin_o) == $past(high_ph_r))
    else $error("high half does not carry high phase");

  // low half of the last period carried the low phase
  a_low_drive: assert property (@(posedge clk)
    disable iff (!reset_n)
    $past(pin_out.pin_o) == $past(low_ph_r))
    else $error("low half does not carry low phase");

  // enable follows the request one edge later
  a_enable_follow: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en |=> pin_out.pin_oe == $past(drive_en))
    else $error("enable does not follow request");

  // a dropped request lets go of the pin on the next edge
  a_release_drive: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en && !drive_en |=> !pin_out.pin_oe)
    else $error("pin not released");

  // a released pin is captured and reaches the core
  a_release_pin: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && clk_en && !pin_out.pin_oe ##1 clk_en
      |=> rx_pair.rise == $past(pin_in.pin_i, 2))
    else $error("released pin not captured");

  // a low clock enable freezes every rising-edge flop but rst_held_r
  a_freeze_hold: assert property (@(posedge clk)
    disable iff (!reset_n)
    reset_n && !clk_en |=> $stable(rx_pair) && $stable(pin_out.pin_oe)
      && $stable(high_ph_r) && $stable(low_ph_r) && $stable(rise_cap_r))
    else $error("state moved while enable low");

  // and the falling-edge capture as well
  a_fall_freeze: assert property (@(negedge clk)
    disable iff (!reset_n)
    reset_n && !clk_en |=> $stable(fall_cap_r))
    else $error("falling capture moved while enable low");

  // a burst of driven periods
  c_drive_burst: cover property (@(posedge clk) disable iff (!reset_n)
    pin_out.pin_oe [*4]);

  // hand-over from driving to receiving
  c_turnaround: cover property (@(posedge clk) disable iff (!reset_n)
    pin_out.pin_oe ##1 !pin_out.pin_oe ##1 rx_pair.fall);

  // two different bits within one period
  c_both_edges: cover property (@(posedge clk) disable iff (!reset_n)
    rx_pair.rise != rx_pair.fall);

  // a run of frozen cycles
  c_clock_hold: cover property (@(posedge clk) disable iff (!reset_n)
    !clk_en [*3]);

endmodule : ddrio_path

// ==== tb/ddrio_far_end.sv ====
/* far double-rate device model on the shared pin.
   assumes the bench steers it only while the pin is released. */
`timescale 1ns/100ps
module ddrio_far_end
  import ddrio_pkg::*;
(
  input  wire logic           clk,
  input  wire ddrio_pin_out_t dev,
  input  wire logic           far_on,
  input  wire logic           rise_v,
  input  wire logic           fall_v,
  output ddrio_pin_in_t       pin
);
  logic far_lvl;
  logic pin_lvl;
  logic last_r = 1'h0;
  // ==========================================================
  // far drive: rise value in low half, fall value in high half
  assign far_lvl = clk ? fall_v : rise_v;
  // released pin shows inverse of last level, never a stale copy
  always_comb begin
    if (dev.pin_oe) pin_lvl = dev.pin_o;
    else if (far_on) pin_lvl = far_lvl;
    else pin_lvl = ~last_r;
  end
  // wire delay keeps the pin off the sampling edges of both captures
  assign #1 pin.pin_i = pin_lvl;
  always @(posedge clk or negedge clk) last_r <= pin.pin_i;
endmodule : ddrio_far_end

// ==== tb/ddr_io_register_path_test.sv ====
/* bench: output pairs then input pairs for every bit combination.
   assumes the far model resolves the shared pin. */
`timescale 1ns/100ps
module ddr_io_register_path_test import ddrio_pkg::*;;
  logic           clk = 1'h0;
  logic           reset_n = 1'h0;
  logic           h = 1'h0;
  logic           l = 1'h0;
  logic           en = 1'h0;
  logic           ce = 1'h1;
  logic           far_on = 1'h0;
  logic           rv = 1'h0;
  logic           fv = 1'h0;
  ddrio_pin_in_t  pin;
  ddrio_pin_out_t pout;
  ddrio_pair_t    rx;
  int             n_mismatch = 0;
  int             cmp_count = 0;
  always #4 clk = ~clk;
  ddrio_path i_ddrio_path (.clk(clk), .reset_n(reset_n), .clk_en(ce),
    .pin_in(pin), .pin_out(pout), .data_in_h(h), .data_in_l(l),
    .drive_en(en), .rx_pair(rx));
  ddrio_far_end i_ddrio_far_end (.clk(clk), .dev(pout), .far_on(far_on),
    .rise_v(rv), .fall_v(fv), .pin(pin));
  // ==========================================================
  task automatic chk(input logic seen, input logic exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %b seen %b", nm, exp, seen);
    end
  endtask : chk
  // sampled 2 ns into each half so the mux has settled
  task automatic out_pair;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      h <= i[1];
      l <= i[0];
      en <= 1'h1;
      @(posedge clk);
      #2;
      chk(pout.pin_oe, 1'h1, "oe");
      chk(pout.pin_o, i[1], "high");
      @(negedge clk);
      #2;
      chk(pout.pin_o, i[0], "low");
    end
  endtask : out_pair
  task automatic in_pair;
    @(posedge clk);
    en <= 1'h0;
    far_on <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rv <= i[1];
      fv <= i[0];
      repeat (2) @(posedge clk);
      #2;
      chk(pout.pin_oe, 1'h0, "oe off");
      chk(rx.rise, i[1], "rise");
      chk(rx.fall, i[0], "fall");
    end
  endtask : in_pair
  // enable low: nothing moves, whatever the inputs do
  task automatic hold_state;
    @(posedge clk);
    rv <= 1'h0;
    fv <= 1'h1;
    repeat (2) @(posedge clk);
    ce <= 1'h0;
    rv <= 1'h1;
    fv <= 1'h0;
    en <= 1'h1;
    repeat (3) @(posedge clk);
    #2;
    chk(rx.rise, 1'h0, "held rise");
    chk(rx.fall, 1'h1, "held fall");
    chk(pout.pin_oe, 1'h0, "held oe");
    @(posedge clk);
    ce <= 1'h1;
    en <= 1'h0;
  endtask : hold_state
  // reset in mid-run while driving, then the first pair after it
  task automatic reset_mid;
    @(posedge clk);
    h <= 1'h1;
    l <= 1'h1;
    en <= 1'h1;
    @(posedge clk);
    reset_n <= 1'h0;
    l <= 1'h0;
    repeat (2) @(posedge clk);
    #2;
    chk(pout.pin_oe, 1'h0, "reset oe");
    chk(pout.pin_o, 1'h0, "reset pin");
    chk(rx.rise, 1'h0, "reset rise");
    chk(rx.fall, 1'h0, "reset fall");
    @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    #2;
    chk(pout.pin_oe, 1'h1, "first oe");
    chk(pout.pin_o, 1'h1, "first high");
    @(negedge clk);
    #2;
    chk(pout.pin_o, 1'h0, "first low");
    @(posedge clk);
    en <= 1'h0;
  endtask : reset_mid
  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    out_pair();
    in_pair();
    hold_state();
    reset_mid();
    conclude();
  end
  // watchdog far beyond the few dozen cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : ddr_io_register_path_test
